// ---- verilog/bbiow_regs.v ----
`timescale 1ns/1ns
`include "bbiow_map.vh"
module bbiow_regs (
   input  wire        i_sys_clk,
   input  wire        i_nrst,
   // AHB-Lite slave
   input  wire        i_hsel,
   input  wire [31:0] i_haddr,
   input  wire [1:0]  i_htrans,
   input  wire        i_hwrite,
   input  wire [2:0]  i_hsize,
   input  wire        i_hready,
   input  wire [31:0] i_hwdata,
   output reg  [31:0] o_hrdata,
   output wire        o_hreadyout,
   output wire        o_hresp,
   // Secondary side events and I/O forwarding
   input  wire        i_sec_par_err,
   input  wire        i_io_req,
   input  wire [31:0] i_io_addr,
   output wire        o_io_fwd_valid,
   output wire        o_io_fwd,
   output wire [7:0]  o_sec_bus,
   output wire [7:0]  o_sub_bus
);

   ////////////////////////////////////////////////////////////////////////
   // Registers

   reg  [7:0]  sec_bus_q;
   reg  [7:0]  sub_bus_q;
   reg  [3:0]  io_base_q;
   reg  [3:0]  io_limit_q;
   reg  [15:0] io_base_up_q;
   reg  [15:0] io_limit_up_q;
   reg         par_resp_en_q;
   reg         mdpe_q;

   // Bus pipeline
   reg         wr_pend_q;
   reg  [7:0]  wr_addr_q;
   reg         rd_wait_q;
   reg  [7:0]  rd_addr_q;

   wire        addr_ok;
   wire        wr_bus;
   wire        wr_iostat;
   wire        wr_ioup;
   wire        wr_brctl;
   wire        mdpe_set;
   reg  [31:0] rd_mux;
   wire [31:0] win_base;
   wire [31:0] win_limit;

   ////////////////////////////////////////////////////////////////////////
   // AHB-Lite address and data phases

   // Reads take one wait state so a read that follows a write sees the
   // value the write just stored; writes complete with no wait.
   assign o_hreadyout = ~rd_wait_q;
   assign o_hresp     = `BBIOW_HRESP_OKAY;

   // Only whole-word transfers are taken; other sizes complete as no-ops
   assign addr_ok = i_hsel & i_htrans[1] & i_hready
                    & (i_hsize == `BBIOW_HSIZE_WORD);

   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         rd_wait_q <= 1'b0;
         rd_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= addr_ok & i_hwrite;
         rd_wait_q <= addr_ok & ~i_hwrite;
         if (addr_ok & i_hwrite) begin
            wr_addr_q <= i_haddr[7:0];
         end
         if (addr_ok & ~i_hwrite) begin
            rd_addr_q <= i_haddr[7:0];
         end
      end
   end

   assign wr_bus    = wr_pend_q & (wr_addr_q == `BBIOW_OFS_BUS);
   assign wr_iostat = wr_pend_q & (wr_addr_q == `BBIOW_OFS_IOSTAT);
   assign wr_ioup   = wr_pend_q & (wr_addr_q == `BBIOW_OFS_IOUP);
   assign wr_brctl  = wr_pend_q & (wr_addr_q == `BBIOW_OFS_BRCTL);

   ////////////////////////////////////////////////////////////////////////
   // Writable fields

   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sec_bus_q     <= `BBIOW_BUS_RST;
         sub_bus_q     <= `BBIOW_BUS_RST;
         io_base_q     <= `BBIOW_NIB_RST;
         io_limit_q    <= `BBIOW_NIB_RST;
         io_base_up_q  <= `BBIOW_UP_RST;
         io_limit_up_q <= `BBIOW_UP_RST;
         par_resp_en_q <= `BBIOW_FLAG_RST;
      end else begin
         if (wr_bus) begin
            sec_bus_q <= i_hwdata[`BBIOW_SEC_LSB +: 8];
            sub_bus_q <= i_hwdata[`BBIOW_SUB_LSB +: 8];
         end
         if (wr_iostat) begin
            io_base_q  <= i_hwdata[`BBIOW_IOB_LSB +: 4];
            io_limit_q <= i_hwdata[`BBIOW_IOL_LSB +: 4];
         end
         if (wr_ioup) begin
            io_base_up_q  <= i_hwdata[`BBIOW_IOBU_LSB +: 16];
            io_limit_up_q <= i_hwdata[`BBIOW_IOLU_LSB +: 16];
         end
         if (wr_brctl) begin
            par_resp_en_q <= i_hwdata[`BBIOW_PERE_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Master data parity flag

   assign mdpe_set = i_sec_par_err & par_resp_en_q;

   // A parity event in the clearing cycle wins so no error is lost
   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         mdpe_q <= `BBIOW_FLAG_RST;
      end else if (mdpe_set) begin
         mdpe_q <= 1'b1;
      end else if (wr_iostat & i_hwdata[`BBIOW_MDPE_BIT]) begin
         mdpe_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data

   // Hardwired fields come from constants, so writes never reach them
   always @* begin
      rd_mux = 32'h0000_0000;
      case (rd_addr_q)
         `BBIOW_OFS_BUS: begin
            rd_mux[`BBIOW_SEC_LSB +: 8] = sec_bus_q;
            rd_mux[`BBIOW_SUB_LSB +: 8] = sub_bus_q;
            rd_mux[`BBIOW_LAT_LSB +: 8] = `BBIOW_LAT_VAL;
         end
         `BBIOW_OFS_IOSTAT: begin
            rd_mux[`BBIOW_IOB_CAP_LSB +: 4] = `BBIOW_IO_CAP;
            rd_mux[`BBIOW_IOB_LSB +: 4]     = io_base_q;
            rd_mux[`BBIOW_IOL_CAP_LSB +: 4] = `BBIOW_IO_CAP;
            rd_mux[`BBIOW_IOL_LSB +: 4]     = io_limit_q;
            rd_mux[`BBIOW_M66_BIT]          = `BBIOW_M66_VAL;
            rd_mux[`BBIOW_FB2B_BIT]         = `BBIOW_FB2B_VAL;
            rd_mux[`BBIOW_MDPE_BIT]         = mdpe_q;
         end
         `BBIOW_OFS_IOUP: begin
            rd_mux[`BBIOW_IOBU_LSB +: 16] = io_base_up_q;
            rd_mux[`BBIOW_IOLU_LSB +: 16] = io_limit_up_q;
         end
         `BBIOW_OFS_BRCTL: begin
            rd_mux[`BBIOW_PERE_BIT] = par_resp_en_q;
         end
         default: begin
            rd_mux = 32'h0000_0000;
         end
      endcase
   end

   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_hrdata <= 32'h0000_0000;
      end else if (rd_wait_q) begin
         o_hrdata <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // I/O window

   assign win_base  = {io_base_up_q, io_base_q,
                       `BBIOW_IO_LO_BASE};
   assign win_limit = {io_limit_up_q, io_limit_q,
                       `BBIOW_IO_LO_LIMIT};

   bbiow_win_cmp #(
      .AW (32)
   ) u_win (
      .i_sys_clk (i_sys_clk),
      .i_nrst    (i_nrst),
      .i_base    (win_base),
      .i_limit   (win_limit),
      .i_req     (i_io_req),
      .i_addr    (i_io_addr),
      .o_valid   (o_io_fwd_valid),
      .o_hit     (o_io_fwd)
   );

   assign o_sec_bus = sec_bus_q;
   assign o_sub_bus = sub_bus_q;

endmodule

// ---- verilog/bbiow_map.vh ----
`ifndef BBIOW_MAP_VH
`define BBIOW_MAP_VH

// Register byte offsets (low address byte only)
`define BBIOW_OFS_BUS      8'h18
`define BBIOW_OFS_IOSTAT   8'h1c
`define BBIOW_OFS_IOUP     8'h30
`define BBIOW_OFS_BRCTL    8'h3c

// Field positions, bus number word
`define BBIOW_SEC_LSB      8
`define BBIOW_SUB_LSB      16
`define BBIOW_LAT_LSB      24

// Field positions, I/O window and secondary status word
`define BBIOW_IOB_CAP_LSB  0
`define BBIOW_IOB_LSB      4
`define BBIOW_IOL_CAP_LSB  8
`define BBIOW_IOL_LSB      12
`define BBIOW_M66_BIT      21
`define BBIOW_FB2B_BIT     23
`define BBIOW_MDPE_BIT     24

// Field positions, I/O upper halves and bridge control
`define BBIOW_IOBU_LSB     0
`define BBIOW_IOLU_LSB     16
`define BBIOW_PERE_BIT     16

// Constant and reset values
`define BBIOW_IO_CAP       4'h1
`define BBIOW_LAT_VAL      8'h00
`define BBIOW_M66_VAL      1'b0
`define BBIOW_FB2B_VAL     1'b0
`define BBIOW_BUS_RST      8'h00
`define BBIOW_NIB_RST      4'h0
`define BBIOW_UP_RST       16'h0000
`define BBIOW_FLAG_RST     1'b0
`define BBIOW_IO_LO_BASE   12'h000
`define BBIOW_IO_LO_LIMIT  12'hfff

// AHB-Lite encodings
`define BBIOW_HSIZE_WORD   3'b010
`define BBIOW_HRESP_OKAY   1'b0

`endif

// ---- verilog/bbiow_win_cmp.v ----
`timescale 1ns/1ns
// Registered I/O window check: hit when base <= addr <= limit.
module bbiow_win_cmp #(
   parameter AW = 32
) (
   input  wire          i_sys_clk,
   input  wire          i_nrst,
   input  wire [AW-1:0] i_base,
   input  wire [AW-1:0] i_limit,
   input  wire          i_req,
   input  wire [AW-1:0] i_addr,
   output reg           o_valid,
   output reg           o_hit
);

   wire hit_d;

   // An empty window (limit below base) never hits
   assign hit_d = (i_addr >= i_base) && (i_addr <= i_limit);

   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_valid <= 1'b0;
         o_hit   <= 1'b0;
      end else begin
         o_valid <= i_req;
         o_hit   <= i_req & hit_d;
      end
   end

endmodule

// ---- dv/bbiow_regs_chk.sv ----
`timescale 1ns/1ns
module bbiow_regs_chk (
   input wire        i_sys_clk,
   input wire        i_nrst,
   input wire        i_hsel,
   input wire [31:0] i_haddr,
   input wire [1:0]  i_htrans,
   input wire        i_hwrite,
   input wire [2:0]  i_hsize,
   input wire        i_hready,
   input wire [31:0] i_hwdata,
   input wire [31:0] o_hrdata,
   input wire        o_hreadyout,
   input wire        i_io_req,
   input wire        o_io_fwd_valid,
   input wire        o_io_fwd,
   input wire [7:0]  o_sec_bus,
   input wire [7:0]  o_sub_bus
);
   // Data-phase tag: write flag and low address, 0ff when bus is idle
   wire       tk = i_hsel & i_htrans[1] & i_hready & (i_hsize == 3'b010);
   reg  [8:0] a_q;
   always @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst)
         a_q <= 9'h0ff;
      else
         a_q <= tk ? {i_hwrite, i_haddr[7:0]} : 9'h0ff;
   end
   wire rd18 = !o_hreadyout && a_q == 9'h018;
   wire rd1c = !o_hreadyout && a_q == 9'h01c;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_nrst);
   AST_FWD_VLD: assert property (o_io_fwd_valid == $past(i_io_req))
      else $error("late forward valid");
   AST_LAT: assert property (rd18 |=> o_hrdata[31:24] == 8'h00)
      else $error("latency field not zero");
   AST_RD_SUB: assert property (rd18 |=> o_hrdata[23:16] == o_sub_bus)
      else $error("subordinate read wrong");
   AST_RD_SEC: assert property (rd18 |=> o_hrdata[15:8] == o_sec_bus)
      else $error("secondary read wrong");
   AST_CAP: assert property (rd1c |=> o_hrdata[11:8] == 4'h1 &&
      o_hrdata[3:0] == 4'h1) else $error("capability nibble wrong");
   AST_STAT: assert property (rd1c |=> !o_hrdata[21] && !o_hrdata[23])
      else $error("status bit not zero");
   AST_WR_SUB: assert property (a_q == 9'h118 |=>
      o_sub_bus == $past(i_hwdata[23:16])) else $error("subordinate write");
   AST_WR_SEC: assert property (a_q == 9'h118 |=>
      o_sec_bus == $past(i_hwdata[15:8])) else $error("secondary write");
   cover property (rd1c);
   cover property (a_q == 9'h118);
   cover property (o_io_fwd_valid && o_io_fwd);
endmodule
bind bbiow_regs bbiow_regs_chk u_bbiow_regs_chk (.*);

// ---- dv/bridge_bus_io_window_regs_bench.sv ----
`timescale 1ns/1ns
module bridge_bus_io_window_regs_bench;
   reg         clk = 1'b0;
   reg         nrst = 1'b0;
   reg         hsel = 1'b0;
   reg  [31:0] haddr = 32'h0;
   reg  [1:0]  htrans = 2'h0;
   reg         hwrite = 1'b0;
   reg  [31:0] hwdata = 32'h0;
   reg         perr = 1'b0;
   reg         ioreq = 1'b0;
   reg  [31:0] ioaddr = 32'h0;
   reg  [31:0] d;
   wire [31:0] hrdata;
   wire        hrdy;
   wire        hresp;
   wire        fwdv;
   wire        fwd;
   wire [7:0]  secb;
   wire [7:0]  subb;
   integer     fails = 0;
   integer     num_checks = 0;
   always #4 clk = ~clk;
   bbiow_regs u_bbiow_regs (
      .i_sys_clk(clk), .i_nrst(nrst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010),
      .i_hready(hrdy), .i_hwdata(hwdata), .o_hrdata(hrdata),
      .o_hreadyout(hrdy), .o_hresp(hresp), .i_sec_par_err(perr),
      .i_io_req(ioreq), .i_io_addr(ioaddr), .o_io_fwd_valid(fwdv),
      .o_io_fwd(fwd), .o_sec_bus(secb), .o_sub_bus(subb));
   task conclude;
      begin
         $display("checks %0d mismatches %0d", num_checks, fails);
         if (fails == 0 && num_checks > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
         end
      end
   endtask
   // Ready and read data are read before this edge's updates land, so
   // they are the values the slave showed at the rising edge
   task phase;
      integer n;
      begin
         n = 0;
         @(posedge clk);
         while (hrdy !== 1'b1 && n < 50) begin
            n = n + 1;
            @(posedge clk);
         end
         if (n == 50) begin
            fails = fails + 1;
            conclude;
         end
         d = hrdata;
      end
   endtask
   task xfer(input w, input [31:0] a, input [31:0] wd);
      begin
         hsel <= 1'b1;
         htrans <= 2'h2;
         hwrite <= w;
         haddr <= a;
         phase;
         htrans <= 2'h0;
         hwdata <= wd;
         phase;
      end
   endtask
   task rd(input [31:0] a, input [31:0] exp);
      begin
         xfer(1'b0, a, 32'h0);
         chk(d, exp);
         chk({31'h0, hresp}, 32'h0);
      end
   endtask
   task io(input [31:0] a, input hit);
      begin
         ioreq <= 1'b1;
         ioaddr <= a;
         @(posedge clk);
         ioreq <= 1'b0;
         @(negedge clk);
         chk({30'h0, fwdv, fwd}, {30'h0, 1'b1, hit});
         @(posedge clk);
      end
   endtask
   task par;
      begin
         perr <= 1'b1;
         @(posedge clk);
         perr <= 1'b0;
         @(posedge clk);
      end
   endtask
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd(32'h18, 32'h0);
      rd(32'h1c, 32'h0000_0101);
      $display("test reset done");
      xfer(1'b1, 32'h18, 32'hffff_ffff);
      rd(32'h18, 32'h00ff_ff00);
      chk({16'h0, subb, secb}, 32'h0000_ffff);
      xfer(1'b1, 32'h18, 32'h0000_a500);
      rd(32'h18, 32'h0000_a500);
      xfer(1'b1, 32'h1c, 32'hffff_ffff);
      rd(32'h1c, 32'h0000_f1f1);
      xfer(1'b1, 32'h40, 32'hffff_ffff);
      rd(32'h40, 32'h0);
      $display("test fields done");
      xfer(1'b1, 32'h30, 32'h0001_0001);
      xfer(1'b1, 32'h1c, 32'h0000_5030);
      io(32'h0001_2fff, 1'b0);
      io(32'h0001_3000, 1'b1);
      io(32'h0001_5fff, 1'b1);
      io(32'h0001_6000, 1'b0);
      io(32'h0000_3000, 1'b0);
      $display("test window done");
      par;
      rd(32'h1c, 32'h0000_5131);
      xfer(1'b1, 32'h3c, 32'h0001_0000);
      par;
      rd(32'h1c, 32'h0100_5131);
      xfer(1'b1, 32'h1c, 32'h0100_5030);
      rd(32'h1c, 32'h0000_5131);
      $display("test parity done");
      conclude;
   end
endmodule
